// >>> core/pps_pkg.sv
// Shared constants and types for the programmable packet sequencer
package pps_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_HDR_LEN = 8'h00;
  localparam logic [7:0] OFF_DATA_LEN = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_MATCH = 8'h0c;
  localparam logic [7:0] OFF_POL = 8'h10;
  localparam logic [7:0] OFF_ROUTE = 8'h14;
  localparam logic [7:0] OFF_UC_ADDR = 8'h18;
  localparam logic [7:0] OFF_UC_DATA = 8'h1c;
  localparam logic [7:0] OFF_XL_ADDR = 8'h20;
  localparam logic [7:0] OFF_XL_DATA = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_SEQ = 8'h2c;

  // Control register bit positions
  localparam int unsigned CTRL_PKT_EN = 0;
  localparam int unsigned CTRL_SEQ_RUN = 1;
  localparam int unsigned CTRL_SOFT_CLR = 2;

  // Reset values of the host-written registers
  localparam logic [7:0] RST_HDR_LEN = 8'h00;
  localparam logic [7:0] RST_DATA_LEN = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic RST_ROUTE = 1'b0;

  // Data, microcode and translation table sizes
  localparam int unsigned DW = 8;
  localparam int unsigned UC_AW = 6;
  localparam int unsigned UC_W = 25;
  localparam int unsigned XL_AW = 8;

  // Test condition selectors carried in a microword
  localparam logic [1:0] TS_DP0 = 2'h0;
  localparam logic [1:0] TS_DP1 = 2'h1;
  localparam logic [1:0] TS_MATCH = 2'h2;
  localparam logic [1:0] TS_IN_PKT = 2'h3;

  // Microword layout, most significant field first
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] delay;
    logic [1:0] tsel;
    logic branch;
    logic [UC_AW-1:0] next;
  } pps_uword_t;

  typedef enum logic [2:0] {
    PK_IDLE = 3'b001,
    PK_HDR = 3'b010,
    PK_DATA = 3'b100
  } pps_pkt_st_t;

  typedef enum logic [2:0] {
    SQ_FETCH = 3'b001,
    SQ_EXEC = 3'b010,
    SQ_WAIT = 3'b100
  } pps_seq_st_t;

  // Incoming stream word
  typedef struct packed {
    logic valid;
    logic [DW-1:0] data;
  } pps_word_t;

  // Outgoing stream word with its packet tags
  typedef struct packed {
    logic sop;
    logic hdr;
    logic valid;
    logic [DW-1:0] data;
  } pps_stream_t;

  // AHB-Lite master side toward the slave
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } pps_ahb_req_t;

  // AHB-Lite slave answer
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } pps_ahb_rsp_t;

endpackage

// >>> core/pps_dpram.sv
// Flip-flop dual-port RAM: one write port, one registered read port
`timescale 1ns/100ps
`default_nettype none

module pps_dpram #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 256
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } pps_ram_st_t;

  pps_ram_st_t q;
  pps_ram_st_t d;

  // Refuse sizes the address arithmetic cannot serve
  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("pps_dpram: DEPTH must be at least 2 and W at least 1");
  end

  // Write and read work independently; a read of the entry being written gives old data
  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
    d.rdata = q.mem[rd_addr];
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rdata;

endmodule

`default_nettype wire

// >>> core/pps_core.sv
// Programmable packet sequencer: registers, packet length machine, microsequencer
//
// Functional notes
// - Length values live in host read/write registers, not in fixed logic.
// - Machine loads header counter from register, counts only in header state.
// - Header counter counts down; on done the header state is left.
// - Data word count register loads a second counter governing the data state.
// - Each microcode word holds next-state field and datapath control outputs.
// - Host writes microcode via write port; sequencer reads via independent port.
// - Fixed address generator forms next address; test conditions alter sequence.
// - Delay compare registers load from values fetched from microcode.
// - Comparator flags stream word equal to host-programmed match value.
// - Reloadable dual-port RAM lookup translates incoming codes.
// - Incoming data XORed with host polarity bits, inverting where one.
// - Host select register steers result data onto chosen destination bus.
`timescale 1ns/100ps
`default_nettype none

module pps_core #(
  parameter int unsigned UC_DEPTH = 64,
  parameter int unsigned XL_DEPTH = 256
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register port
  input wire pps_pkg::pps_ahb_req_t ahb_req,
  output pps_pkg::pps_ahb_rsp_t ahb_rsp,
  // Incoming stream and datapath test conditions
  input wire pps_pkg::pps_word_t in_word,
  input wire logic [1:0] dp_test,
  // Destination buses
  output pps_pkg::pps_stream_t dest0,
  output pps_pkg::pps_stream_t dest1,
  // Microcoded control outputs to the datapath
  output logic [7:0] uctrl
);
  import pps_pkg::*;

  typedef struct packed {
    pps_ahb_rsp_t rsp;
    logic pend;
    logic pwrite;
    logic phit;
    logic [7:0] paddr;
    logic [7:0] hdr_len;
    logic [7:0] data_len;
    logic [7:0] match;
    logic [7:0] pol;
    logic route;
    logic pkt_en;
    logic seq_run;
    logic [UC_AW-1:0] uc_addr;
    logic [XL_AW-1:0] xl_addr;
    pps_pkt_st_t pst;
    logic [7:0] hcnt;
    logic [7:0] dcnt;
    pps_stream_t s1;
    pps_stream_t d0;
    pps_stream_t d1;
    pps_seq_st_t sst;
    logic [UC_AW-1:0] uaddr;
    logic [7:0] dly_cmp;
    logic [7:0] tmr;
    logic [7:0] uctrl;
  } pps_core_st_t;

  // All module state in one record; the comb block builds the next copy
  pps_core_st_t q;
  pps_core_st_t d;

  // Microcode depth and translation depth are fixed by the word layout
  // The microword next field and the table index set these depths
  if (UC_DEPTH != (1 << UC_AW) || XL_DEPTH != (1 << XL_AW)) begin : g_chk
    $error("pps_core: UC_DEPTH must be 64 and XL_DEPTH 256");
  end

  // Decoded strobes and datapath taps shared by the next-state logic
  logic host_wr;
  logic uc_we;
  logic xl_we;
  logic soft_clr;
  logic [UC_W-1:0] uc_rdata;
  logic [DW-1:0] xl_rdata;
  logic [DW-1:0] pol_data;
  logic match_hit;
  pps_uword_t uw;

  // Host write strobes, taken in the data phase of a write
  assign host_wr = q.pend && q.pwrite && q.phit;
  assign uc_we = host_wr && (q.paddr == OFF_UC_DATA);
  assign xl_we = host_wr && (q.paddr == OFF_XL_DATA);
  assign soft_clr = host_wr && (q.paddr == OFF_CTRL) && ahb_req.hwdata[CTRL_SOFT_CLR];

  // Polarity inversion and start-symbol comparator
  assign pol_data = in_word.data ^ q.pol;
  assign match_hit = in_word.valid && (pol_data == q.match);

  // Microcode store: host fills it while the sequencer fetches
  pps_dpram #(
    .W(UC_W),
    .DEPTH(UC_DEPTH)
  ) u_ucode (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(uc_we),
    .wr_addr(q.uc_addr),
    .wr_data(ahb_req.hwdata[UC_W-1:0]),
    .rd_addr(q.uaddr),
    .rd_data(uc_rdata)
  );

  // Code conversion table, reloadable by the host
  pps_dpram #(
    .W(DW),
    .DEPTH(XL_DEPTH)
  ) u_xlat (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(xl_we),
    .wr_addr(q.xl_addr),
    .wr_data(ahb_req.hwdata[DW-1:0]),
    .rd_addr(pol_data),
    .rd_data(xl_rdata)
  );

  assign uw = pps_uword_t'(uc_rdata);

  // Read-back multiplexer for the register file
  // Write-only and unmapped offsets read as zero so software sees no stale data
  function automatic logic [31:0] pps_rd_mux(input pps_core_st_t s, input logic hit);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (hit) begin
      case (s.paddr)
        OFF_HDR_LEN: r[7:0] = s.hdr_len;
        OFF_DATA_LEN: r[7:0] = s.data_len;
        OFF_CTRL: r[CTRL_SEQ_RUN:CTRL_PKT_EN] = {s.seq_run, s.pkt_en};
        OFF_MATCH: r[7:0] = s.match;
        OFF_POL: r[7:0] = s.pol;
        OFF_ROUTE: r[0] = s.route;
        OFF_UC_ADDR: r[UC_AW-1:0] = s.uc_addr;
        OFF_XL_ADDR: r[XL_AW-1:0] = s.xl_addr;
        OFF_STATUS: r[18:0] = {s.pst, s.dcnt, s.hcnt};
        OFF_SEQ: r[24:0] = {s.sst, s.dly_cmp, s.uaddr, s.uctrl};
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  // Next-state logic for bus slave, packet machine, stream and sequencer
  always_comb begin
    logic hdr_act;
    logic dat_act;
    logic idle_like;
    logic tcond;
    logic [3:0] tests;
    logic [UC_AW-1:0] nxt;
    pps_stream_t tag;
    pps_stream_t res;
    // Scratch values are cleared first so no latch is inferred
    hdr_act = 1'b0;
    dat_act = 1'b0;
    idle_like = 1'b0;
    tcond = 1'b0;
    tests = 4'h0;
    nxt = '0;
    tag = '0;
    res = '0;
    d = q;

    // Bus slave: one wait state, then write applied or read data presented
    // The wait state lets a read that follows a write see the new value
    // Write data is sampled in the data phase, one edge after the address
    d.rsp.hreadyout = 1'b1;
    d.rsp.hresp = 1'b0;
    if (q.pend) begin
      d.pend = 1'b0;
      if (q.pwrite) begin
        if (q.phit) begin
          case (q.paddr)
            OFF_HDR_LEN: d.hdr_len = ahb_req.hwdata[7:0];
            OFF_DATA_LEN: d.data_len = ahb_req.hwdata[7:0];
            OFF_CTRL: begin
              d.pkt_en = ahb_req.hwdata[CTRL_PKT_EN];
              d.seq_run = ahb_req.hwdata[CTRL_SEQ_RUN];
            end
            OFF_MATCH: d.match = ahb_req.hwdata[7:0];
            OFF_POL: d.pol = ahb_req.hwdata[7:0];
            OFF_ROUTE: d.route = ahb_req.hwdata[0];
            OFF_UC_ADDR: d.uc_addr = ahb_req.hwdata[UC_AW-1:0];
            OFF_UC_DATA: d.uc_addr = q.uc_addr + 1'b1;
            OFF_XL_ADDR: d.xl_addr = ahb_req.hwdata[XL_AW-1:0];
            OFF_XL_DATA: d.xl_addr = q.xl_addr + 1'b1;
            default: d.hdr_len = q.hdr_len;
          endcase
        end
      end else begin
        d.rsp.hrdata = pps_rd_mux(q, q.phit);
      end
    end else if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
      d.pend = 1'b1;
      d.pwrite = ahb_req.hwrite;
      d.paddr = ahb_req.haddr[7:0];
      d.phit = (ahb_req.haddr[31:8] == 24'h00_0000) && (ahb_req.haddr[1:0] == 2'b00);
      d.rsp.hreadyout = 1'b0;
    end

    // Phase qualifiers; done means the counter stands at zero
    // The header-done cycle doubles as the first data cycle, so no word is lost
    // between phases; idle_like lets a start symbol land as the data count ends
    hdr_act = (q.pst == PK_HDR) && (q.hcnt != 8'h00);
    dat_act = ((q.pst == PK_DATA) || ((q.pst == PK_HDR) && (q.hcnt == 8'h00)))
      && (q.dcnt != 8'h00);
    idle_like = (q.pst == PK_IDLE) || ((q.pst == PK_DATA) && (q.dcnt == 8'h00));

    // Packet length machine
    // State leaves HDR and DATA on counter done; the block below counts words and enters HDR on a start symbol
    case (q.pst)
      PK_IDLE: begin
        d.pst = PK_IDLE;
      end
      PK_HDR: begin
        if (q.hcnt == 8'h00) begin
          d.pst = PK_DATA;
        end
      end
      PK_DATA: begin
        if (q.dcnt == 8'h00) begin
          d.pst = PK_IDLE;
        end
      end
      default: d.pst = PK_IDLE;
    endcase
    if (in_word.valid) begin
      if (hdr_act) begin
        d.hcnt = q.hcnt - 1'b1;
        tag = '{sop: 1'b0, hdr: 1'b1, valid: 1'b1, data: pol_data};
      end else if (dat_act) begin
        d.dcnt = q.dcnt - 1'b1;
        tag = '{sop: 1'b0, hdr: 1'b0, valid: 1'b1, data: pol_data};
      end else if (idle_like && q.pkt_en && match_hit) begin
        d.hcnt = q.hdr_len;
        d.dcnt = q.data_len;
        d.pst = PK_HDR;
        tag = '{sop: 1'b1, hdr: 1'b0, valid: 1'b1, data: pol_data};
      end
    end

    // Stream pipeline: translate, then route to one destination
    // The table read is registered, so the tag waits one stage in s1 to line up
    // with translated data; the unused destination is held at zero
    d.s1 = tag;
    res = q.s1;
    res.data = xl_rdata;
    d.d0 = q.route ? pps_stream_t'('0) : res;
    d.d1 = q.route ? res : pps_stream_t'('0);

    // Microsequencer: fetch, execute, optional programmed delay
    // The microcode read port is registered: FETCH presents the address and EXEC
    // sees the word. A zero delay field skips the wait state entirely.
    // WAIT compares the incremented timer so a delay of N holds exactly N cycles
    tests = {(q.pst != PK_IDLE), match_hit, dp_test};
    tcond = tests[uw.tsel];
    nxt = (uw.branch && tcond) ? uw.next : q.uaddr + 1'b1;
    case (q.sst)
      SQ_FETCH: begin
        if (q.seq_run) begin
          d.sst = SQ_EXEC;
        end
      end
      SQ_EXEC: begin
        d.uctrl = uw.ctrl;
        d.uaddr = nxt;
        if (uw.delay != 8'h00) begin
          d.dly_cmp = uw.delay;
          d.tmr = 8'h00;
          d.sst = SQ_WAIT;
        end else begin
          d.sst = SQ_FETCH;
        end
      end
      SQ_WAIT: begin
        d.tmr = q.tmr + 1'b1;
        if (d.tmr == q.dly_cmp) begin
          d.sst = SQ_FETCH;
        end
      end
      default: d.sst = SQ_FETCH;
    endcase
    // Stopping the sequencer parks it in FETCH with the address held
    if (!q.seq_run) begin
      d.sst = SQ_FETCH;
    end

    // Soft clear: idle both machines, clear counters, keep configuration
    // It overrides the machine and counter updates above; it has no stored bit and reads zero
    if (soft_clr) begin
      d.pst = PK_IDLE;
      d.hcnt = 8'h00;
      d.dcnt = 8'h00;
      d.sst = SQ_FETCH;
      d.uaddr = '0;
      d.tmr = 8'h00;
      d.dly_cmp = 8'h00;
      d.uctrl = 8'h00;
      d.s1 = '0;
    end
  end

  // State register
  // Configuration resets to package defaults; bus ready idles high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.rsp.hreadyout <= 1'b1;
      q.hdr_len <= RST_HDR_LEN;
      q.data_len <= RST_DATA_LEN;
      q.match <= RST_MATCH;
      q.pol <= RST_POL;
      q.route <= RST_ROUTE;
      q.pst <= PK_IDLE;
      q.sst <= SQ_FETCH;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  // Every output is a register field, so no combinational path reaches a pin
  assign ahb_rsp = q.rsp;
  assign dest0 = q.d0;
  assign dest1 = q.d1;
  assign uctrl = q.uctrl;

endmodule

`default_nettype wire

// >>> verification/pps_core_assertions.sv
// Concurrent checks on the packet sequencer top-level ports
`timescale 1ns/100ps
`default_nettype none

module pps_core_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire pps_pkg::pps_ahb_req_t ahb_req,
  input wire pps_pkg::pps_ahb_rsp_t ahb_rsp,
  // Stream and datapath
  input wire pps_pkg::pps_word_t in_word,
  input wire logic [1:0] dp_test,
  input wire pps_pkg::pps_stream_t dest0,
  input wire pps_pkg::pps_stream_t dest1,
  input wire logic [7:0] uctrl
);
  import pps_pkg::*;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Address phase accepted by the slave
  sequence taken_s;
    ahb_req.hsel && ahb_req.htrans[1] && ahb_rsp.hreadyout;
  endsequence

  // Exactly one wait state, then ready again
  sequence one_wait_s;
    !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endsequence

  a_take_one_wait: assert property (taken_s |=> one_wait_s)
    else $error("bus transfer without exactly one wait state");
  a_stall_needs_req: assert property (!ahb_rsp.hreadyout |->
    $past(ahb_req.hsel && ahb_req.htrans[1] && ahb_rsp.hreadyout))
    else $error("bus stalled without a request");
  a_resp_okay: assert property (ahb_rsp.hresp == 1'b0)
    else $error("bus response not okay");
  a_route_only0: assert property (dest0.valid |-> dest1 == '0)
    else $error("second bus active while first carries data");
  a_route_only1: assert property (dest1.valid |-> dest0 == '0)
    else $error("first bus active while second carries data");
  a_out_from_in: assert property ((dest0.valid || dest1.valid) |-> $past(in_word.valid, 2))
    else $error("output word without an input two cycles before");
  a_tags_valid: assert property ((dest0.sop || dest0.hdr) |-> dest0.valid)
    else $error("packet tag without a valid word");
  a_uctrl_spaced: assert property ($changed(uctrl) |=> $stable(uctrl))
    else $error("control outputs changed on two cycles in a row");
endmodule

`default_nettype wire

// >>> verification/pps_host_model.sv
// Host processor model issuing single AHB-Lite word transfers
`timescale 1ns/100ps
`default_nettype none

module pps_host_model (
  // Clock
  input wire logic hclk,
  // Register bus
  output pps_pkg::pps_ahb_req_t ahb_req,
  input wire pps_pkg::pps_ahb_rsp_t ahb_rsp
);
  import pps_pkg::*;

  pps_ahb_req_t r;
  int n_timeouts;

  // Idle bus at time zero
  initial begin
    r = '0;
    n_timeouts = 0;
  end

  // Bus hready is the single slave's hreadyout
  always_comb begin
    ahb_req = r;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  // Wait for hready high at a rising edge, bounded
  task automatic wait_ready();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (ahb_rsp.hreadyout === 1'b1) break;
    end
    if (i == 16) n_timeouts++;
  endtask

  // One single word transfer: address phase, then data phase on the separate write data bus
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    r.hsel <= 1'b1;
    r.haddr <= {24'h0, a};
    r.htrans <= 2'h2;
    r.hwrite <= wr;
    r.hsize <= 3'h2;
    wait_ready();
    // Released address shows inverted, data phase carries the write data
    r.hsel <= 1'b0;
    r.htrans <= 2'h0;
    r.haddr <= ~{24'h0, a};
    r.hwdata <= wd;
    wait_ready();
    rd = ahb_rsp.hrdata;
    r.hwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the programmable packet sequencer
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module testbench;
  import pps_pkg::*;

  logic hclk;
  logic hresetn;
  pps_ahb_req_t ahb_req;
  pps_ahb_rsp_t ahb_rsp;
  pps_word_t in_word;
  logic [1:0] dp_test;
  pps_stream_t dest0;
  pps_stream_t dest1;
  logic [7:0] uctrl;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rdv;
  logic [7:0] ulast = 8'h00;
  logic [10:0] outq[$];
  logic [7:0] uq[$];
  int ut[$];

  pps_host_model host (.hclk(hclk), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));

  pps_core DUT (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .in_word(in_word), .dp_test(dp_test), .dest0(dest0), .dest1(dest1), .uctrl(uctrl));

  // 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Record output words with their bus, and every change of the control outputs
  always @(posedge hclk) begin
    cyc++;
    if (dest0.valid || dest1.valid) begin
      outq.push_back({dest1.valid, dest0.sop | dest1.sop,
        (dest0.hdr | dest1.hdr) & ~(dest0.sop | dest1.sop), dest0.data | dest1.data});
    end
    if (uctrl !== ulast) begin
      uq.push_back(uctrl);
      ut.push_back(cyc);
    end
    ulast = uctrl;
  end

  task automatic final_report();
    err_count += host.n_timeouts;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdv);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    host.xfer(1'b0, a, 32'h0, rdv);
    `CHK(nm, e, rdv)
  endtask

  task automatic send(input logic [7:0] d);
    in_word <= '{valid: 1'b1, data: d};
    @(posedge hclk);
  endtask

  // Reset values, write/read back, upper bits, unmapped place
  task automatic t_regs();
    for (logic [7:0] a = 8'h00; a < 8'h28; a += 8'h04) begin
      rchk(a, 32'h0, "reset value");
    end
    rchk(OFF_STATUS, 32'h10000, "status idle");
    rchk(OFF_SEQ, 32'h400000, "seq idle");
    wr(OFF_HDR_LEN, 32'hffffffff);
    rchk(OFF_HDR_LEN, 32'hff, "hdr_len");
    wr(OFF_DATA_LEN, 32'ha5);
    rchk(OFF_DATA_LEN, 32'ha5, "data_len");
    wr(8'h30, 32'h1);
    rchk(8'h30, 32'h0, "unmapped");
  endtask

  // Load the whole translation table; the pointer wraps to zero
  task automatic t_xlat();
    wr(OFF_XL_ADDR, 32'h0);
    for (int i = 0; i < 256; i++) begin
      wr(OFF_XL_DATA, {24'h0, 8'(i) ^ 8'h3c});
    end
    rchk(OFF_XL_ADDR, 32'h0, "xl_addr");
  endtask

  // Noise, start symbol, a gap, header, data, trailing noise
  task automatic t_pkt(input logic rt, input logic [7:0] hl, input logic [7:0] dl);
    logic [10:0] exp[$];
    logic [7:0] v;
    wr(OFF_ROUTE, {31'h0, rt});
    wr(OFF_HDR_LEN, {24'h0, hl});
    wr(OFF_DATA_LEN, {24'h0, dl});
    outq = {};
    send(8'h55);
    send(8'h71);
    exp.push_back({rt, 2'b10, 8'h7e ^ 8'h3c});
    in_word <= '{valid: 1'b0, data: ~in_word.data};
    @(posedge hclk);
    for (int i = 0; i < hl + dl; i++) begin
      v = 8'(i * 7 + 3);
      send(v);
      exp.push_back({rt, 1'b0, i < hl, v ^ 8'h0f ^ 8'h3c});
    end
    send(8'h10);
    in_word <= '{valid: 1'b0, data: ~in_word.data};
    repeat (4) @(posedge hclk);
    `CHK("pkt count", exp.size(), outq.size())
    for (int i = 0; i < exp.size() && i < outq.size(); i++) begin
      `CHK("pkt word", exp[i], outq[i])
    end
    rchk(OFF_STATUS, 32'h10000, "status end");
  endtask

  // Compare recorded control output changes with a list
  task automatic uchk(input logic [7:0] e[$]);
    `CHK("uctrl count", e.size(), uq.size())
    for (int i = 0; i < e.size() && i < uq.size(); i++) begin
      `CHK("uctrl", e[i], uq[i])
    end
  endtask

  // Microprogram with branches on test inputs and one delay
  task automatic t_seq();
    pps_uword_t uw[5];
    uw[0] = '{ctrl: 8'h11, delay: 8'h0, tsel: TS_DP0, branch: 1'b1, next: 6'h2};
    uw[1] = '{ctrl: 8'h22, delay: 8'h0, tsel: TS_IN_PKT, branch: 1'b1, next: 6'h4};
    uw[2] = '{ctrl: 8'h33, delay: 8'h3, tsel: TS_DP1, branch: 1'b1, next: 6'h0};
    uw[3] = '{ctrl: 8'h44, delay: 8'h0, tsel: TS_DP0, branch: 1'b1, next: 6'h3};
    uw[4] = '{ctrl: 8'h00, delay: 8'h0, tsel: TS_MATCH, branch: 1'b1, next: 6'h1};
    wr(OFF_UC_ADDR, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_UC_DATA, {7'h0, uw[i]});
    end
    dp_test <= 2'b01;
    uq = {};
    ut = {};
    wr(OFF_CTRL, 32'h3);
    repeat (30) @(posedge hclk);
    uchk('{8'h11, 8'h33, 8'h44});
    if (ut.size() == 3) begin
      `CHK("delay gap", 3, (ut[2] - ut[1]) - (ut[1] - ut[0]))
    end
    wr(OFF_CTRL, 32'h1);
    dp_test <= 2'b00;
    uq = {};
    wr(OFF_CTRL, 32'h7);
    repeat (30) @(posedge hclk);
    uchk('{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00});
    rchk(OFF_HDR_LEN, 32'h3, "config kept");
  endtask

  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    final_report();
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    in_word = '0;
    dp_test = 2'b00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_xlat();
    wr(OFF_MATCH, 32'h7e);
    wr(OFF_POL, 32'h0f);
    wr(OFF_CTRL, 32'h1);
    t_pkt(1'b0, 8'h2, 8'h3);
    t_pkt(1'b1, 8'h3, 8'h1);
    t_seq();
    final_report();
  end
endmodule

bind pps_core pps_core_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
  .ahb_rsp(ahb_rsp), .in_word(in_word), .dp_test(dp_test), .dest0(dest0), .dest1(dest1),
  .uctrl(uctrl));

`default_nettype wire
